// >>> mfp_ctrl.v
// multifunction pin control: pin config, modes, input combining, divider sync
//
// Function
// - ten pins, config registers 0x0103 to 0x010C
// - config write stops old pin function immediately
// - new function starts on update strobe write
// - mode 00: low deasserted, high asserted
// - mode 01: high deasserted, low asserted
// - mode 10: released deasserted, drive high asserted
// - mode 11: released deasserted, drive low asserted
// - config msb one: pin monitors internal function
// - config msb zero: pin controls internal function
// - input codes 00/01 ANDed with OR result
// - mode register holds two bits per pin
// - dividers static until first sync event
// - sync input pin triggers manual divider sync
// - loop lock or reference sync triggers sync
// - ignoring channel pulses once, ignores later syncs
// - interrupt output is OR of monitor bits
// - watchdog timeout gives 96-cycle pin pulse
// - clear-all-interrupts pin clears monitor bits
`include "mfp_regs.vh"

module mfp_ctrl (
   input  wire                    clk,
   input  wire                    resetn,
   input  wire                    reg_wr,
   input  wire                    reg_rd,
   input  wire [15:0]             reg_addr,
   input  wire [7:0]              reg_wdata,
   output reg  [7:0]              reg_rdata,
   input  wire [`MFP_NPINS-1:0]   multifunction_pin_i,
   output reg  [`MFP_NPINS-1:0]   multifunction_pin_o,
   output reg  [`MFP_NPINS-1:0]   multifunction_pin_oe,
   input  wire [`MFP_IRQ_W-1:0]   irq_monitor,
   output reg                     irq_clear_all,
   input  wire                    wdog_timeout,
   output reg                     wdog_reset,
   input  wire [`MFP_NLOOP-1:0]   digital_phase_loop_lock,
   input  wire [`MFP_NLOOP-1:0]   lock_sync_en,
   input  wire [`MFP_NLOOP-1:0]   ref_sync_event,
   input  wire [`MFP_NLOOP-1:0]   ref_sync_en,
   input  wire                    sync_reg_req,
   input  wire                    profile_load_sync,
   input  wire [`MFP_NCH-1:0]     ch_ignore_sync,
   output reg  [`MFP_NCH-1:0]     ch_sync_pulse,
   output reg  [`MFP_NCH-1:0]     ch_hold
);

   // ------------------------------------------------------------
   // register write decode
   // ------------------------------------------------------------
   wire                  upd_strobe;
   wire [`MFP_NPINS-1:0] pin_level;
   wire                  wdog_stretched;

   // update strobe: write of the update value to the update register
   assign upd_strobe = reg_wr && (reg_addr == `MFP_ADDR_UPDATE)
                       && (reg_wdata == `MFP_UPDATE_VAL);

   // mode registers: written copy and active copy (two bits per pin)
   reg [19:0] mode_wr;
   reg [19:0] mode_act;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode_wr  <= `MFP_MODE_RESET;
         mode_act <= `MFP_MODE_RESET;
      end else begin
         if (reg_wr && reg_addr == `MFP_ADDR_MODE0) begin
            mode_wr[7:0] <= reg_wdata;
         end
         if (reg_wr && reg_addr == `MFP_ADDR_MODE1) begin
            mode_wr[15:8] <= reg_wdata;
         end
         if (reg_wr && reg_addr == `MFP_ADDR_MODE2) begin
            mode_wr[19:16] <= reg_wdata[3:0];
         end
         if (upd_strobe) begin
            mode_act <= mode_wr;
         end
      end
   end

   // ------------------------------------------------------------
   // input synchroniser and watchdog pulse stretcher
   // ------------------------------------------------------------
   mfp_sync3 u_sync (
      .clk       (clk),
      .resetn    (resetn),
      .pin_raw   (multifunction_pin_i),
      .pin_level (pin_level)
   );

   mfp_stretch u_wdog (
      .clk    (clk),
      .resetn (resetn),
      .trig   (wdog_timeout),
      .pulse  (wdog_stretched)
   );

   // ------------------------------------------------------------
   // per-pin configuration and output drive
   // ------------------------------------------------------------
   wire [8*`MFP_NPINS-1:0] cfg_wr_flat;
   wire [`MFP_NPINS-1:0]   pend;
   wire [`MFP_NPINS-1:0]   sel_clr;
   wire [`MFP_NPINS-1:0]   sel_sync;
   wire [`MFP_NPINS-1:0]   sel_wdr;
   wire [`MFP_NPINS-1:0]   in_term;
   wire [`MFP_NPINS-1:0]   in_or;
   wire                    irq_any;
   wire                    all_synced;

   assign irq_any    = |irq_monitor;
   assign all_synced = ~(|ch_hold);

   genvar i;
   generate
      for (i = 0; i < `MFP_NPINS; i = i + 1) begin : g_pin
         localparam [15:0] CFG_ADDR = `MFP_ADDR_CFG_FIRST + i;
         reg  [7:0] cfg_wr;
         reg  [7:0] cfg_act;
         reg        cfg_pend;
         reg        fval;
         wire [1:0] md;
         wire       is_out;
         wire       asrt;
         wire [6:0] code;

         assign md     = mode_act[2*i+1:2*i];
         assign code   = cfg_act[6:0];
         assign is_out = cfg_act[`MFP_CFG_DIR_BIT];
         assign cfg_wr_flat[8*i+7:8*i] = cfg_wr;
         assign pend[i] = cfg_pend;

         // config write arms pending; update strobe activates it
         always @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               cfg_wr   <= `MFP_CFG_RESET;
               cfg_act  <= `MFP_CFG_RESET;
               cfg_pend <= 1'b0;
            end else if (reg_wr && reg_addr == CFG_ADDR) begin
               cfg_wr   <= reg_wdata;
               cfg_pend <= 1'b1;
            end else if (upd_strobe) begin
               cfg_act  <= cfg_wr;
               cfg_pend <= 1'b0;
            end
         end

         // monitored internal function chosen by the low seven bits
         always @* begin
            case (code)
               `MFP_OUT_IRQ:    fval = irq_any;
               `MFP_OUT_WDOG:   fval = wdog_stretched;
               `MFP_OUT_SYNCED: fval = all_synced;
               `MFP_OUT_LOCK0:  fval = digital_phase_loop_lock[0];
               `MFP_OUT_LOCK1:  fval = digital_phase_loop_lock[1];
               `MFP_OUT_LOCK2:  fval = digital_phase_loop_lock[2];
               `MFP_OUT_LOCK3:  fval = digital_phase_loop_lock[3];
               default:         fval = 1'b0;
            endcase
         end

         // pending pin is held deasserted
         assign asrt = is_out & ~cfg_pend & fval;

         // drive per mode; input pins are released
         always @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               multifunction_pin_o[i]  <= 1'b0;
               multifunction_pin_oe[i] <= 1'b0;
            end else if (!is_out) begin
               multifunction_pin_o[i]  <= 1'b0;
               multifunction_pin_oe[i] <= 1'b0;
            end else begin
               case (md)
                  `MFP_MODE_HIGH: begin
                     multifunction_pin_o[i]  <= asrt;
                     multifunction_pin_oe[i] <= 1'b1;
                  end
                  `MFP_MODE_LOW: begin
                     multifunction_pin_o[i]  <= ~asrt;
                     multifunction_pin_oe[i] <= 1'b1;
                  end
                  `MFP_MODE_ODP: begin
                     multifunction_pin_o[i]  <= 1'b1;
                     multifunction_pin_oe[i] <= asrt;
                  end
                  default: begin
                     multifunction_pin_o[i]  <= 1'b0;
                     multifunction_pin_oe[i] <= asrt;
                  end
               endcase
            end
         end

         // input selection per control function; pending pins ignored
         assign sel_clr[i]  = ~is_out & ~cfg_pend & (code == `MFP_IN_CLR_IRQ);
         assign sel_sync[i] = ~is_out & ~cfg_pend & (code == `MFP_IN_SYNC);
         assign sel_wdr[i]  = ~is_out & ~cfg_pend & (code == `MFP_IN_WD_RST);
         assign in_term[i]  = pin_level[i] ^ md[0];
         assign in_or[i]    = md[1];
      end
   endgenerate

   // ------------------------------------------------------------
   // input combining: OR group then AND with the rest
   // ------------------------------------------------------------
   function comb_in;
      input [`MFP_NPINS-1:0] sel;
      input [`MFP_NPINS-1:0] term;
      input [`MFP_NPINS-1:0] orm;
      reg   [`MFP_NPINS-1:0] or_sel;
      reg   [`MFP_NPINS-1:0] and_sel;
      begin
         or_sel  = sel & orm;
         and_sel = sel & ~orm;
         comb_in = (|sel) & (~(|or_sel) | (|(or_sel & term)))
                   & ~(|(and_sel & ~term));
      end
   endfunction

   reg  clr_lvl;
   reg  sync_lvl;
   reg  wdr_lvl;
   wire pin_sync_rise;

   // registered combined levels and the clear and watchdog-reset rising-edge events
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         clr_lvl       <= 1'b0;
         sync_lvl      <= 1'b0;
         wdr_lvl       <= 1'b0;
         irq_clear_all <= 1'b0;
         wdog_reset    <= 1'b0;
      end else begin
         clr_lvl       <= comb_in(sel_clr, in_term, in_or);
         sync_lvl      <= comb_in(sel_sync, in_term, in_or);
         wdr_lvl       <= comb_in(sel_wdr, in_term, in_or);
         irq_clear_all <= comb_in(sel_clr, in_term, in_or) & ~clr_lvl;
         wdog_reset    <= comb_in(sel_wdr, in_term, in_or) & ~wdr_lvl;
      end
   end

   assign pin_sync_rise = comb_in(sel_sync, in_term, in_or) & ~sync_lvl;

   // ------------------------------------------------------------
   // divider synchronisation
   // ------------------------------------------------------------
   reg  [`MFP_NLOOP-1:0] lock_prev;
   wire                  auto_sync;
   wire                  sync_event;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lock_prev <= {`MFP_NLOOP{1'b0}};
      end else begin
         lock_prev <= digital_phase_loop_lock;
      end
   end

   // loop lock edge or reference sync, when the loop selects it
   assign auto_sync  = |((digital_phase_loop_lock & ~lock_prev & lock_sync_en)
                         | (ref_sync_event & ref_sync_en));
   assign sync_event = sync_reg_req | profile_load_sync | pin_sync_rise
                       | auto_sync;

   reg [`MFP_NCH-1:0] ign_prev;

   genvar c;
   generate
      for (c = 0; c < `MFP_NCH; c = c + 1) begin : g_ch
         // ignoring channel fires once on entry, then disregards syncs
         always @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               ign_prev[c]      <= 1'b0;
               ch_sync_pulse[c] <= 1'b0;
               ch_hold[c]       <= 1'b1;
            end else begin
               ign_prev[c] <= ch_ignore_sync[c];
               if (ch_ignore_sync[c]) begin
                  ch_sync_pulse[c] <= ~ign_prev[c];
                  if (!ign_prev[c]) begin
                     ch_hold[c] <= 1'b0;
                  end
               end else begin
                  ch_sync_pulse[c] <= sync_event;
                  if (sync_event) begin
                     ch_hold[c] <= 1'b0;
                  end
               end
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // register readback, one cycle after the read strobe
   // ------------------------------------------------------------
   reg [7:0]  rd_mux;
   reg [15:0] cfg_idx;

   always @* begin
      cfg_idx = reg_addr - `MFP_ADDR_CFG_FIRST;
      rd_mux  = 8'h00;
      if (reg_addr == `MFP_ADDR_MODE0) begin
         rd_mux = mode_wr[7:0];
      end else if (reg_addr == `MFP_ADDR_MODE1) begin
         rd_mux = mode_wr[15:8];
      end else if (reg_addr == `MFP_ADDR_MODE2) begin
         rd_mux = {4'h0, mode_wr[19:16]};
      end else if (reg_addr >= `MFP_ADDR_CFG_FIRST && reg_addr <= `MFP_ADDR_CFG_LAST) begin
         rd_mux = cfg_wr_flat[8*cfg_idx +: 8];
      end else if (reg_addr == `MFP_ADDR_LVL_LO) begin
         rd_mux = pin_level[7:0];
      end else if (reg_addr == `MFP_ADDR_LVL_HI) begin
         rd_mux = {6'h00, pin_level[9:8]};
      end else if (reg_addr == `MFP_ADDR_PEND_LO) begin
         rd_mux = pend[7:0];
      end else if (reg_addr == `MFP_ADDR_PEND_HI) begin
         rd_mux = {6'h00, pend[9:8]};
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end
   end

endmodule

// >>> mfp_regs.vh
// register offsets, field codes and timing counts for the multifunction pin block
`ifndef MFP_REGS_VH
`define MFP_REGS_VH

// ------------------------------------------------------------
// sizes
// ------------------------------------------------------------
`define MFP_NPINS          10
`define MFP_NCH            8
`define MFP_NLOOP          4
`define MFP_IRQ_W          16

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define MFP_ADDR_UPDATE    16'h000F
`define MFP_ADDR_MODE0     16'h0100
`define MFP_ADDR_MODE1     16'h0101
`define MFP_ADDR_MODE2     16'h0102
`define MFP_ADDR_CFG_FIRST 16'h0103
`define MFP_ADDR_CFG_LAST  16'h010C
`define MFP_ADDR_LVL_LO    16'h01F0
`define MFP_ADDR_LVL_HI    16'h01F1
`define MFP_ADDR_PEND_LO   16'h01F2
`define MFP_ADDR_PEND_HI   16'h01F3

// ------------------------------------------------------------
// values and fields
// ------------------------------------------------------------
`define MFP_UPDATE_VAL     8'h01
`define MFP_CFG_RESET      8'h00
`define MFP_MODE_RESET     20'h00000
`define MFP_CFG_DIR_BIT    7
`define MFP_MODE_HIGH      2'h0
`define MFP_MODE_LOW       2'h1
`define MFP_MODE_ODP       2'h2
`define MFP_MODE_ODN       2'h3

// output (monitor) function codes
`define MFP_OUT_IRQ        7'h01
`define MFP_OUT_WDOG       7'h02
`define MFP_OUT_SYNCED     7'h03
`define MFP_OUT_LOCK0      7'h04
`define MFP_OUT_LOCK1      7'h05
`define MFP_OUT_LOCK2      7'h06
`define MFP_OUT_LOCK3      7'h07

// input (control) function codes
`define MFP_IN_CLR_IRQ     7'h01
`define MFP_IN_SYNC        7'h02
`define MFP_IN_WD_RST      7'h03

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define MFP_WDOG_PULSE_CYC 7'd96
`define MFP_WDOG_LOAD      (`MFP_WDOG_PULSE_CYC - 7'd1)

`endif

// >>> mfp_sync3.v
// three-stage pin synchroniser with agreement filter
`include "mfp_regs.vh"

module mfp_sync3 (
   input  wire                    clk,
   input  wire                    resetn,
   input  wire [`MFP_NPINS-1:0]   pin_raw,
   output wire [`MFP_NPINS-1:0]   pin_level
);

   reg [`MFP_NPINS-1:0] s1;
   reg [`MFP_NPINS-1:0] s2;
   reg [`MFP_NPINS-1:0] s3;
   reg [`MFP_NPINS-1:0] lvl;

   assign pin_level = lvl;

   genvar i;
   generate
      for (i = 0; i < `MFP_NPINS; i = i + 1) begin : g_bit
         // s1 feeds only s2; level moves once s2 and s3 agree
         always @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               s1[i]  <= 1'b0;
               s2[i]  <= 1'b0;
               s3[i]  <= 1'b0;
               lvl[i] <= 1'b0;
            end else begin
               s1[i] <= pin_raw[i];
               s2[i] <= s1[i];
               s3[i] <= s2[i];
               if (s2[i] == s3[i]) begin
                  lvl[i] <= s3[i];
               end
            end
         end
      end
   endgenerate

endmodule

// >>> mfp_stretch.v
// stretches a one-cycle event into a fixed-length pulse
`include "mfp_regs.vh"

module mfp_stretch (
   input  wire clk,
   input  wire resetn,
   input  wire trig,
   output reg  pulse
);

   reg [6:0] cnt;

   // a new trigger restarts the full length
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt   <= 7'h00;
         pulse <= 1'b0;
      end else if (trig) begin
         cnt   <= `MFP_WDOG_LOAD;
         pulse <= 1'b1;
      end else if (cnt != 7'h00) begin
         cnt   <= cnt - 7'h01;
      end else begin
         pulse <= 1'b0;
      end
   end

endmodule

// >>> mfp_ctrl_checker.sv
// assertion checker for the multifunction pin control block
`include "mfp_regs.vh"
module mfp_ctrl_checker (
   input wire logic                  clk,
   input wire logic                  resetn,
   input wire logic                  reg_rd,
   input wire logic [15:0]           reg_addr,
   input wire logic [7:0]            reg_rdata,
   input wire logic                  irq_clear_all,
   input wire logic                  wdog_reset,
   input wire logic                  sync_reg_req,
   input wire logic                  profile_load_sync,
   input wire logic [`MFP_NCH-1:0]   ch_ignore_sync,
   input wire logic [`MFP_NCH-1:0]   ch_sync_pulse,
   input wire logic [`MFP_NCH-1:0]   ch_hold
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   logic [`MFP_NCH-1:0] ign_q;
   logic [`MFP_NCH-1:0] ign_rise;
   // ------------------------------------------------------------
   // helper: previous ignore setting and its rising bits
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) ign_q <= '0;
      else ign_q <= ch_ignore_sync;
   end
   assign ign_rise = ch_ignore_sync & ~ign_q;
   // register and profile sync sources
   sequence s_sync_src;
      sync_reg_req || profile_load_sync;
   endsequence
   property p_sync;
      s_sync_src |=> ((ch_sync_pulse | $past(ch_ignore_sync)) == {`MFP_NCH{1'b1}});
   endproperty
   AST_SYNC_SRC: assert property (p_sync) else $error("sync source gave no pulse");
   AST_IGNORE_ONCE: assert property (|ign_rise |=>
      ((ch_sync_pulse & $past(ign_rise)) == $past(ign_rise))) else $error("no ignore pulse");
   AST_IGNORE_QUIET: assert property ((ch_sync_pulse & ign_q & $past(ign_q)) == '0)
      else $error("ignoring channel pulsed");
   AST_HOLD_CLEAR: assert property ((ch_sync_pulse & ch_hold) == '0)
      else $error("hold kept during sync pulse");
   AST_HOLD_NO_RISE: assert property ((ch_hold & ~$past(ch_hold)) == '0)
      else $error("hold set again");
   AST_CLR_ONE: assert property (irq_clear_all |=> !irq_clear_all)
      else $error("clear pulse too long");
   AST_WDR_ONE: assert property (wdog_reset |=> !wdog_reset)
      else $error("watchdog reset pulse too long");
   AST_RDATA_STANDS: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without read");
   AST_UNMAPPED: assert property (reg_rd && reg_addr == 16'h010D |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule
bind mfp_ctrl mfp_ctrl_checker i_chk (.clk(clk), .resetn(resetn), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_rdata(reg_rdata), .irq_clear_all(irq_clear_all),
   .wdog_reset(wdog_reset), .sync_reg_req(sync_reg_req), .profile_load_sync(profile_load_sync),
   .ch_ignore_sync(ch_ignore_sync), .ch_sync_pulse(ch_sync_pulse), .ch_hold(ch_hold));

// >>> mfp_board.sv
// board model for the multifunction pins: pull resistors and external drivers
`include "mfp_regs.vh"
module mfp_board #(
   parameter logic [`MFP_NPINS-1:0] PULL_UP = 10'h3E0
) (
   input  wire logic [`MFP_NPINS-1:0] pin_o,
   input  wire logic [`MFP_NPINS-1:0] pin_oe,
   input  wire logic [`MFP_NPINS-1:0] ext_drive,
   input  wire logic [`MFP_NPINS-1:0] ext_en,
   output wire logic [`MFP_NPINS-1:0] pin_level
);
   timeunit 1ns;
   timeprecision 100ps;
   // device drive wins, then board driver, else pull-up (pins 5-9) or pull-down (pins 0-4)
   assign pin_level = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_drive)
                    | (~pin_oe & ~ext_en & PULL_UP);
endmodule

// >>> multifunction_pin_control_tb_top.sv
// self-checking testbench for the multifunction pin control block
`include "mfp_regs.vh"
module multifunction_pin_control_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic                    clk, resetn, reg_wr, reg_rd, irq_clear_all, wdog_timeout;
   logic                    wdog_reset, sync_reg_req, profile_load_sync;
   logic [15:0]             reg_addr;
   logic [7:0]              reg_wdata, reg_rdata;
   logic [`MFP_NPINS-1:0]   pin_i, pin_o, pin_oe, ext_drive, ext_en;
   logic [`MFP_IRQ_W-1:0]   irq_monitor;
   logic [`MFP_NLOOP-1:0]   lock, lock_sync_en, ref_sync_event, ref_sync_en;
   logic [`MFP_NCH-1:0]     ch_ignore_sync, ch_sync_pulse, ch_hold;
   int                      miscompares, num_checks;
   mfp_ctrl i_dut (.clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .multifunction_pin_i(pin_i), .multifunction_pin_o(pin_o), .multifunction_pin_oe(pin_oe),
      .irq_monitor(irq_monitor), .irq_clear_all(irq_clear_all), .wdog_timeout(wdog_timeout),
      .wdog_reset(wdog_reset), .digital_phase_loop_lock(lock), .lock_sync_en(lock_sync_en),
      .ref_sync_event(ref_sync_event), .ref_sync_en(ref_sync_en), .sync_reg_req(sync_reg_req),
      .profile_load_sync(profile_load_sync), .ch_ignore_sync(ch_ignore_sync),
      .ch_sync_pulse(ch_sync_pulse), .ch_hold(ch_hold));
   mfp_board i_board (.pin_o(pin_o), .pin_oe(pin_oe), .ext_drive(ext_drive), .ext_en(ext_en),
      .pin_level(pin_i));
   // ------------------------------------------------------------
   // clock, checks and bus tasks
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      tick();
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick();
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      tick();
      reg_addr = a;
      reg_rd = 1'b1;
      tick();
      reg_rd = 1'b0;
      check("read data", reg_rdata, exp);
   endtask
   task automatic upd();
      wr(`MFP_ADDR_UPDATE, `MFP_UPDATE_VAL);
      tick(2);
   endtask
   // counts pulses of one event output over ten cycles
   task automatic count_pulses(input string what, input int sel, input int exp);
      int n;
      n = 0;
      repeat (10) begin
         tick();
         if ((sel == 0 && irq_clear_all === 1'b1) || (sel == 1 && wdog_reset === 1'b1)
             || (sel == 2 && ch_sync_pulse[0] === 1'b1)) n++;
      end
      check(what, n, exp);
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic test_regs();
      check("hold after reset", ch_hold, 8'hFF);
      check("oe after reset", pin_oe, 10'h000);
      wr(16'h010D, 8'h5A);
      rd(16'h010D, 8'h00);
      rd(`MFP_ADDR_CFG_LAST, 8'h00);
      rd(`MFP_ADDR_MODE0, 8'h00);
      wr(`MFP_ADDR_CFG_LAST, 8'h04);
      rd(`MFP_ADDR_CFG_LAST, 8'h04);
      rd(`MFP_ADDR_PEND_HI, 8'h02);
      wr(`MFP_ADDR_MODE2, 8'hFF);
      rd(`MFP_ADDR_MODE2, 8'h0F);
   endtask
   task automatic test_sync();
      ch_ignore_sync[7] = 1'b1;
      tick();
      check("ignore pulse", ch_sync_pulse, 8'h80);
      check("ignore hold", ch_hold, 8'h7F);
      for (int s = 0; s < 5; s++) begin
         sync_reg_req = (s == 0);
         profile_load_sync = (s == 1);
         lock[0] = (s == 2);
         ref_sync_event = {1'b0, (s == 4), (s == 3), 1'b0};
         tick();
         sync_reg_req = 1'b0;
         profile_load_sync = 1'b0;
         lock[0] = 1'b0;
         ref_sync_event = '0;
         check("sync pulse", ch_sync_pulse, (s == 4) ? 8'h00 : 8'h7F);
         check("hold after sync", ch_hold, 8'h00);
         tick(3);
      end
      wr(`MFP_ADDR_CFG_FIRST + 4, 8'h02);
      upd();
      ext_en[4] = 1'b1;
      ext_drive[4] = 1'b1;
      count_pulses("pin sync pulses", 2, 1);
   endtask
   task automatic test_outputs();
      wr(`MFP_ADDR_CFG_FIRST, 8'h81);
      wr(`MFP_ADDR_CFG_FIRST + 1, 8'h81);
      wr(`MFP_ADDR_CFG_FIRST + 5, 8'h81);
      wr(`MFP_ADDR_MODE0, 8'h08);
      wr(`MFP_ADDR_MODE1, 8'h0C);
      rd(`MFP_ADDR_MODE1, 8'h0C);
      irq_monitor = 16'h0100;
      tick(2);
      check("pending outputs", pin_o & 10'h023, 10'h000);
      upd();
      check("asserted levels", pin_i & 10'h023, 10'h003);
      check("asserted enables", pin_oe & 10'h023, 10'h023);
      irq_monitor = 16'h0000;
      tick(2);
      check("idle levels", pin_i & 10'h023, 10'h020);
      check("idle enables", pin_oe & 10'h023, 10'h001);
      wr(`MFP_ADDR_MODE0, 8'h09);
      upd();
      check("low mode idle", pin_i[0], 1'b1);
      irq_monitor = 16'h8000;
      tick(2);
      check("low mode asserted", pin_i[0], 1'b0);
      wr(`MFP_ADDR_CFG_FIRST, 8'h81);
      tick(2);
      check("stopped on write", pin_i[0], 1'b1);
      rd(`MFP_ADDR_CFG_FIRST, 8'h81);
      rd(`MFP_ADDR_PEND_LO, 8'h01);
      wr(`MFP_ADDR_UPDATE, 8'h02);
      tick(2);
      check("bad update ignored", pin_i[0], 1'b1);
      upd();
      check("restarted on update", pin_i[0], 1'b0);
      irq_monitor = 16'h0000;
   endtask
   task automatic test_wdog();
      int n;
      n = 0;
      wr(`MFP_ADDR_CFG_FIRST + 2, 8'h82);
      upd();
      wdog_timeout = 1'b1;
      tick();
      wdog_timeout = 1'b0;
      repeat (150) begin
         tick();
         if (pin_i[2] === 1'b1) n++;
      end
      check("watchdog pulse length", n, 96);
      wr(`MFP_ADDR_CFG_FIRST + 2, 8'h83);
      upd();
      check("released monitor", pin_i[2], 1'b1);
      wr(`MFP_ADDR_CFG_FIRST + 2, 8'h85);
      upd();
      check("lock monitor idle", pin_i[2], 1'b0);
      lock[1] = 1'b1;
      tick(2);
      check("lock monitor", pin_i[2], 1'b1);
      lock[1] = 1'b0;
   endtask
   task automatic test_combine();
      logic [3:0] vec [6] = '{4'b0110, 4'b0111, 4'b1111, 4'b1101, 4'b0101, 4'b0001};
      int exp [6] = '{0, 1, 0, 0, 1, 0};
      ext_drive[4] = 1'b0;
      for (int p = 0; p < 4; p++) wr(`MFP_ADDR_CFG_FIRST + p, 8'h01);
      wr(`MFP_ADDR_CFG_FIRST + 4, 8'h03);
      wr(`MFP_ADDR_MODE0, 8'h4E);
      upd();
      ext_en[3:0] = 4'hF;
      for (int i = 0; i < 6; i++) begin
         ext_drive[3:0] = vec[i];
         count_pulses("clear pulses", 0, exp[i]);
      end
      ext_drive[4] = 1'b1;
      count_pulses("watchdog reset pulses", 1, 1);
      rd(`MFP_ADDR_LVL_LO, 8'hF1);
      rd(`MFP_ADDR_LVL_HI, 8'h03);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      {resetn, reg_wr, reg_rd, wdog_timeout, sync_reg_req, profile_load_sync} = '0;
      {reg_addr, reg_wdata, irq_monitor, lock, ref_sync_event, ch_ignore_sync} = '0;
      {ext_drive, ext_en} = '0;
      lock_sync_en = 4'h1;
      ref_sync_en = 4'h2;
      miscompares = 0;
      num_checks = 0;
      repeat (3) @(posedge clk);
      #1;
      resetn = 1'b1;
      test_regs();
      test_sync();
      test_outputs();
      test_wdog();
      test_combine();
      end_of_test();
   end
   initial begin
      #100us;
      miscompares++;
      end_of_test();
   end
endmodule
